// ---- hw/mem_bus_regs.vh ----
`ifndef MEM_BUS_REGS_VH
`define MEM_BUS_REGS_VH

// Register byte addresses.
`define REG_CFG 8'h00
`define REG_STATUS 8'h04

// Configuration register fields.
`define CFG_RF_EN 0
`define CFG_RF_SEL_LO 1
`define CFG_RF_SEL_HI 2
`define CFG_LATE_WR 3
`define CFG_LEN_LO 4
`define CFG_RESET 32'h0000_0007

// Status register fields.
`define ST_ROW_HI 9
`define ST_GRANT 16
`define ST_BUSY 17
`define ST_RF_PEND 18

// Refresh interval in input clock periods, minus one, per selection.
`define RF_LIMIT_18 7'h11
`define RF_LIMIT_36 7'h23
`define RF_LIMIT_54 7'h35
`define RF_LIMIT_72 7'h47

// Grant appears this many half-cycle units after the rising edge, minus one.
`define GRANT_DELAY 2'h2

// Cycle sequencer states.
`define S_IDLE 4'h0
`define S_RPRE 4'h1
`define S_T1 4'h2
`define S_T2 4'h3
`define S_T3 4'h4
`define S_T4 4'h5
`define S_T5 4'h6
`define S_T6 4'h7
`define S_EXT 4'h8
`define S_GSTART 4'h9
`define S_GRANT 4'ha
`define S_GDROP 4'hb

`endif

// ---- hw/mem_bus_cycles.v ----
`timescale 1ns/1ns
`include "mem_bus_regs.vh"

// Summary of operation
// - Address through T2, then data or float.
// - Address valid strobe asserts at T2 start.
// - Only written byte lanes get write strobes.
// - Two lowest address bits never output.
// - Bit zero low in T1, T2 writes.
// - Bit one low in T1, T2 refresh.
// - Write strobes fall T3 or T4, rise T6.
// - Ten-bit row counter advances per refresh.
// - Refresh on/off, every 18 to 72 clocks.
// - Running cycle finishes before refresh starts.
// - Refresh strobe low before T1 to T6 end.
// - Refresh address word has fixed layout.
// - Strobes behave normally during refresh cycles.
// - Wait sampled in T4, stretches T4.
// - Waits continue while wait input high.
// - After waits, T5 starts on rising edge.
// - Request sampled end of T6 or idle.
// - Grant rises three units after rising edge.
// - Grant drops at falling edge after release.
// - Refresh has priority over DMA grant.
// - Each T state lasts one to four units before waits.
// - Odd cycle length gets extra unit.
module mem_bus_cycles (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire req_valid,
    input wire req_write,
    input wire [31:2] req_addr,
    input wire [31:0] req_wdata,
    input wire [3:0] req_be,
    output reg req_ready,
    output reg resp_valid,
    output reg [31:0] resp_rdata,
    input wire [31:0] shared_addr_data_lines_in,
    output reg [31:0] shared_addr_data_lines_out,
    output reg [31:0] shared_addr_data_lines_oe_n,
    output reg address_valid_strobe_n,
    output reg config_strobe_one_n,
    output reg config_strobe_four_n,
    output reg [3:0] byte_write_strobes_n,
    output reg refresh_cycle_strobe_n,
    input wire wait_input,
    input wire bus_request_in,
    output reg bus_grant_out,
    output reg processor_clock_output
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
reg [2:0] wait_sync;
reg [2:0] req_sync;
reg wait_s;
reg req_s;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        wait_sync <= 3'h0;
        req_sync <= 3'h0;
        wait_s <= 1'b0;
        req_s <= 1'b0;
    end else begin
        wait_sync <= {wait_sync[1:0], wait_input};
        req_sync <= {req_sync[1:0], bus_request_in};
        if (wait_sync[1] == wait_sync[2]) begin
            wait_s <= wait_sync[2];
        end
        if (req_sync[1] == req_sync[2]) begin
            req_s <= req_sync[2];
        end
    end
end

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
reg [31:0] cfg;
reg [9:0] row;
reg rf_pend;
reg [3:0] state;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        cfg <= `CFG_RESET;
        reg_rdata <= 32'h0;
    end else begin
        if (reg_wr && reg_addr == `REG_CFG) begin
            cfg <= {16'h0, reg_wdata[15:0]};
        end
        reg_rdata <= 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CFG: begin
                    reg_rdata <= cfg;
                end
                `REG_STATUS: begin
                    reg_rdata <= {13'h0, rf_pend, (state != `S_IDLE), bus_grant_out, 6'h0, row};
                end
                default: begin
                    reg_rdata <= 32'h0;
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Refresh interval timer
// ----------------------------------------------------------------
reg [6:0] rf_timer;
reg [6:0] rf_limit;
wire rf_hit;
reg start_rf;

always @* begin
    case (cfg[`CFG_RF_SEL_HI:`CFG_RF_SEL_LO])
        2'h0: begin
            rf_limit = `RF_LIMIT_18;
        end
        2'h1: begin
            rf_limit = `RF_LIMIT_36;
        end
        2'h2: begin
            rf_limit = `RF_LIMIT_54;
        end
        default: begin
            rf_limit = `RF_LIMIT_72;
        end
    endcase
end

assign rf_hit = cfg[`CFG_RF_EN] && (rf_timer >= rf_limit);

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rf_timer <= 7'h0;
        rf_pend <= 1'b0;
    end else begin
        if (!cfg[`CFG_RF_EN]) begin
            rf_timer <= 7'h0;
        end else if (rf_hit) begin
            rf_timer <= 7'h0;
        end else begin
            rf_timer <= rf_timer + 7'h1;
        end
        // A new interval elapsing wins over the clear by a starting refresh.
        if (rf_hit) begin
            rf_pend <= 1'b1;
        end else if (start_rf) begin
            rf_pend <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Cycle sequencer
// ----------------------------------------------------------------
reg [1:0] cnt;
reg waited;
reg cyc_write;
reg cyc_refresh;
reg [31:2] cyc_addr;
reg [31:0] cyc_wdata;
reg [3:0] cyc_be;
reg [3:0] next_state;
reg [1:0] next_cnt;
reg next_waited;
reg take_req;
reg end_cyc;
reg [1:0] cur_len;
wire ph;
wire done;

assign ph = processor_clock_output;
assign done = (cnt == cur_len);

// Each T state lasts the configured count plus one half-cycle unit.
always @* begin
    case (state)
        `S_T1: cur_len = cfg[`CFG_LEN_LO+1:`CFG_LEN_LO];
        `S_T2: cur_len = cfg[`CFG_LEN_LO+3:`CFG_LEN_LO+2];
        `S_T3: cur_len = cfg[`CFG_LEN_LO+5:`CFG_LEN_LO+4];
        `S_T4: cur_len = cfg[`CFG_LEN_LO+7:`CFG_LEN_LO+6];
        `S_T5: cur_len = cfg[`CFG_LEN_LO+9:`CFG_LEN_LO+8];
        `S_T6: cur_len = cfg[`CFG_LEN_LO+11:`CFG_LEN_LO+10];
        `S_GSTART: cur_len = `GRANT_DELAY;
        default: cur_len = 2'h0;
    endcase
end

always @* begin
    next_state = state;
    next_cnt = 2'h0;
    next_waited = waited;
    take_req = 1'b0;
    start_rf = 1'b0;
    end_cyc = 1'b0;
    case (state)
        `S_IDLE: begin
            if (rf_pend && ph) begin
                // The next unit is low, so T1 lands on a rising edge.
                next_state = `S_RPRE;
                start_rf = 1'b1;
            end else if (!ph && !rf_pend && req_s) begin
                next_state = `S_GSTART;
            end else if (!ph && !rf_pend && req_valid) begin
                next_state = `S_T1;
                take_req = 1'b1;
            end
        end
        `S_RPRE: begin
            next_state = `S_T1;
        end
        `S_T1, `S_T2, `S_T3, `S_T5: begin
            if (done) begin
                next_state = state + 4'h1;
            end else begin
                next_cnt = cnt + 2'h1;
            end
        end
        `S_T4: begin
            if (!done) begin
                next_cnt = cnt + 2'h1;
            end else if (wait_s) begin
                next_cnt = cnt;
                next_waited = 1'b1;
            end else if (waited && ph) begin
                next_cnt = cnt;
            end else begin
                next_state = `S_T5;
                next_waited = 1'b0;
            end
        end
        `S_T6: begin
            if (!done) begin
                next_cnt = cnt + 2'h1;
            end else if (ph) begin
                next_state = `S_EXT;
            end else begin
                end_cyc = 1'b1;
            end
        end
        `S_EXT: begin
            end_cyc = 1'b1;
        end
        `S_GSTART: begin
            if (done) begin
                next_state = `S_GRANT;
            end else begin
                next_cnt = cnt + 2'h1;
            end
        end
        `S_GRANT: begin
            if (!ph && !req_s) begin
                next_state = `S_GDROP;
            end
        end
        `S_GDROP: begin
            next_state = `S_IDLE;
        end
        default: begin
            next_state = `S_IDLE;
        end
    endcase
    if (end_cyc) begin
        // The request is only looked at in the final low unit of a cycle.
        if (!rf_pend && req_s) begin
            next_state = `S_GSTART;
        end else begin
            next_state = `S_IDLE;
        end
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        state <= `S_IDLE;
        cnt <= 2'h0;
        waited <= 1'b0;
        processor_clock_output <= 1'b0;
        cyc_write <= 1'b0;
        cyc_refresh <= 1'b0;
        cyc_addr <= 30'h0;
        cyc_wdata <= 32'h0;
        cyc_be <= 4'h0;
        row <= 10'h0;
        req_ready <= 1'b0;
        resp_valid <= 1'b0;
        resp_rdata <= 32'h0;
    end else begin
        state <= next_state;
        cnt <= next_cnt;
        waited <= next_waited;
        processor_clock_output <= ~ph;
        req_ready <= take_req;
        resp_valid <= end_cyc && !cyc_refresh;
        if (take_req) begin
            cyc_write <= req_write;
            cyc_refresh <= 1'b0;
            cyc_addr <= req_addr;
            cyc_wdata <= req_wdata;
            cyc_be <= req_write ? req_be : 4'h0;
        end else if (start_rf) begin
            cyc_write <= 1'b0;
            cyc_refresh <= 1'b1;
            cyc_be <= 4'h0;
        end
        if (state == `S_T5 && done && !cyc_write) begin
            resp_rdata <= shared_addr_data_lines_in;
        end
        if (end_cyc && cyc_refresh) begin
            row <= row + 10'h1;
        end
    end
end

// ----------------------------------------------------------------
// Pin outputs, decoded from the next state
// ----------------------------------------------------------------
wire next_addr_phase;
wire next_data_phase;
wire next_in_cycle;
wire [31:0] addr_word;

assign next_addr_phase = (next_state == `S_T1) || (next_state == `S_T2);
assign next_data_phase = (next_state >= `S_T3) && (next_state <= `S_T6);
assign next_in_cycle = (next_state >= `S_T1) && (next_state <= `S_T6);

// A newly taken request shows its own address in T1, before the cycle registers load.
assign addr_word = take_req ? {req_addr, 1'b1, ~req_write} : cyc_refresh ? {1'b0, {19{1'b1}}, row, 2'b01}
                 : {cyc_addr, 1'b1, ~cyc_write};

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        address_valid_strobe_n <= 1'b1;
        config_strobe_one_n <= 1'b1;
        config_strobe_four_n <= 1'b1;
        refresh_cycle_strobe_n <= 1'b1;
        bus_grant_out <= 1'b0;
    end else begin
        address_valid_strobe_n <= !((next_state >= `S_T2) && (next_state <= `S_T5));
        config_strobe_one_n <= !(next_state == `S_T2);
        config_strobe_four_n <= !((next_state >= `S_T3) && (next_state <= `S_T5));
        refresh_cycle_strobe_n <= !(cyc_refresh_next(next_state, start_rf, cyc_refresh && !take_req));
        bus_grant_out <= (next_state == `S_GRANT) || (next_state == `S_GDROP);
    end
end

function cyc_refresh_next;
    input [3:0] st;
    input starting;
    input refreshing;
    begin
        cyc_refresh_next = starting || (refreshing && (st >= `S_RPRE) && (st <= `S_T6));
    end
endfunction

genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
        wire wr_lane;
        wire strobe_on;
        assign wr_lane = cyc_write && cyc_be[lane];
        assign strobe_on = cfg[`CFG_LATE_WR] ? ((next_state == `S_T4) || (next_state == `S_T5))
                                             : ((next_state >= `S_T3) && (next_state <= `S_T5));
        always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                byte_write_strobes_n[lane] <= 1'b1;
                shared_addr_data_lines_out[8*lane+7:8*lane] <= 8'h00;
                shared_addr_data_lines_oe_n[8*lane+7:8*lane] <= 8'hff;
            end else begin
                byte_write_strobes_n[lane] <= !(wr_lane && strobe_on);
                if (next_addr_phase) begin
                    shared_addr_data_lines_out[8*lane+7:8*lane] <= addr_word[8*lane+7:8*lane];
                    shared_addr_data_lines_oe_n[8*lane+7:8*lane] <= 8'h00;
                end else if (next_data_phase && wr_lane) begin
                    shared_addr_data_lines_out[8*lane+7:8*lane] <= cyc_wdata[8*lane+7:8*lane];
                    shared_addr_data_lines_oe_n[8*lane+7:8*lane] <= 8'h00;
                end else begin
                    shared_addr_data_lines_oe_n[8*lane+7:8*lane] <= 8'hff;
                end
            end
        end
    end
endgenerate

endmodule // mem_bus_cycles

// ---- test/mem_bus_cycles_asserts.sv ----
`timescale 1ns/1ns
// ----
// Pin relations of the memory cycle sequencer.
// ----
module mem_bus_cycles_asserts (
    input wire clk_sys,
    input wire rstn,
    input wire [31:0] shared_addr_data_lines_out,
    input wire [31:0] shared_addr_data_lines_oe_n,
    input wire address_valid_strobe_n,
    input wire config_strobe_one_n,
    input wire config_strobe_four_n,
    input wire [3:0] byte_write_strobes_n,
    input wire refresh_cycle_strobe_n,
    input wire bus_grant_out,
    input wire processor_clock_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Write flag shown in the address phase of the cycle now running.
    reg wr_flag;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            wr_flag <= 1'b1;
        else if ($fell(address_valid_strobe_n))
            wr_flag <= shared_addr_data_lines_out[0];
    end
    lane_drive_a: assert property (
        byte_write_strobes_n != 4'hf |-> shared_addr_data_lines_oe_n == {{8{byte_write_strobes_n[3]}},
        {8{byte_write_strobes_n[2]}}, {8{byte_write_strobes_n[1]}}, {8{byte_write_strobes_n[0]}}})
        else $error("write lanes and line drivers disagree");
    write_flag_a: assert property (
        byte_write_strobes_n != 4'hf |-> !wr_flag) else $error("write strobe without write flag");
    cycle_flag_a: assert property (
        $fell(address_valid_strobe_n) |-> shared_addr_data_lines_out[1] == refresh_cycle_strobe_n)
        else $error("refresh flag wrong in address phase");
    refresh_word_a: assert property (
        $fell(address_valid_strobe_n) && !refresh_cycle_strobe_n |->
        shared_addr_data_lines_out[31:12] == 20'h7ffff && shared_addr_data_lines_out[1:0] == 2'b01)
        else $error("refresh address word malformed");
    addr_phase_a: assert property (
        $fell(address_valid_strobe_n) |-> shared_addr_data_lines_oe_n == 32'h0 &&
        $stable(shared_addr_data_lines_out) && !config_strobe_one_n) else $error("address phase broken");
    strobe_rise_a: assert property (
        (~$past(byte_write_strobes_n) & byte_write_strobes_n) != 4'h0 |->
        byte_write_strobes_n == 4'hf && $rose(address_valid_strobe_n)) else $error("write strobe rose off T6");
    refresh_lead_a: assert property (
        $fell(refresh_cycle_strobe_n) |-> address_valid_strobe_n [*2] ##[1:4] !address_valid_strobe_n)
        else $error("refresh strobe not ahead of T1");
    refresh_tail_a: assert property (
        $rose(refresh_cycle_strobe_n) |-> $past(address_valid_strobe_n)) else $error("refresh strobe ended early");
    grant_float_a: assert property (
        bus_grant_out |-> &shared_addr_data_lines_oe_n && &$past(shared_addr_data_lines_oe_n) &&
        address_valid_strobe_n && refresh_cycle_strobe_n && &byte_write_strobes_n)
        else $error("bus not released under grant");
    strobe_four_a: assert property (
        $fell(config_strobe_four_n) |-> !$past(config_strobe_one_n) && !address_valid_strobe_n)
        else $error("strobe four not at T3 start");
    clock_toggle_a: assert property (
        $past(rstn) |-> processor_clock_output != $past(processor_clock_output))
        else $error("clock output stalled");
endmodule // mem_bus_cycles_asserts

bind mem_bus_cycles mem_bus_cycles_asserts chk (.clk_sys(clk_sys), .rstn(rstn),
    .shared_addr_data_lines_out(shared_addr_data_lines_out), .config_strobe_one_n(config_strobe_one_n),
    .shared_addr_data_lines_oe_n(shared_addr_data_lines_oe_n), .address_valid_strobe_n(address_valid_strobe_n),
    .byte_write_strobes_n(byte_write_strobes_n), .refresh_cycle_strobe_n(refresh_cycle_strobe_n),
    .bus_grant_out(bus_grant_out), .config_strobe_four_n(config_strobe_four_n),
    .processor_clock_output(processor_clock_output));

// ---- test/mem_far_side.sv ----
`timescale 1ns/1ns
// ----
// Word memory, slow responder and DMA master.
// ----
module mem_far_side (
    input wire clk_sys,
    input wire [31:0] shared_addr_data_lines_out,
    input wire [31:0] shared_addr_data_lines_oe_n,
    input wire address_valid_strobe_n,
    input wire [3:0] byte_write_strobes_n,
    input wire [7:0] wait_len,
    input wire dma_want,
    output reg [31:0] shared_addr_data_lines_in = 32'h0,
    output reg wait_input = 1'b0,
    output reg bus_request_in = 1'b0
);
    reg [31:0] mem [0:15];
    reg [31:0] addr = 32'h0;
    reg [7:0] held = 8'h0;
    integer i;
    initial for (i = 0; i < 16; i = i + 1)
        mem[i] = 32'h0;
    // Transparent latch that freezes once the address valid strobe falls.
    always @* if (address_valid_strobe_n)
        addr = shared_addr_data_lines_out;
    always @(posedge clk_sys) begin
        held <= address_valid_strobe_n ? 8'h0 : held + 8'h1;
        // While wait_len is nonzero, wait is high between cycles and for wait_len units of each cycle.
        wait_input <= wait_len != 8'h0 && (address_valid_strobe_n || held < wait_len);
        // The bench keeps ownership shorter than one refresh interval.
        bus_request_in <= dma_want;
        for (i = 0; i < 4; i = i + 1)
            if (!byte_write_strobes_n[i])
                mem[addr[5:2]][8 * i +: 8] <= shared_addr_data_lines_out[8 * i +: 8];
        // Released lines toggle so that stale data never reads as good.
        if (!address_valid_strobe_n && &shared_addr_data_lines_oe_n)
            shared_addr_data_lines_in <= mem[addr[5:2]];
        else
            shared_addr_data_lines_in <= ~shared_addr_data_lines_in;
    end
endmodule // mem_far_side

// ---- test/mem_bus_cycles_test.sv ----
`timescale 1ns/1ns
`include "mem_bus_regs.vh"
module mem_bus_cycles_test;
    reg clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    reg dma_want = 1'b0, p_avs = 1'b1, p_wrb = 1'b1, p_rf = 1'b1;
    reg [7:0] reg_addr = 8'h0, wait_len = 8'h0;
    reg [31:0] reg_wdata = 32'h0, req_wdata = 32'h0, word = 32'h0;
    reg [31:2] req_addr = 30'h0;
    reg [3:0] req_be = 4'h0;
    reg [9:0] row_cur = 10'h0, row_prev = 10'h0;
    wire [9:0] row_step = row_cur - row_prev;
    wire req_ready, resp_valid, address_valid_strobe_n, config_strobe_one_n, config_strobe_four_n;
    wire refresh_cycle_strobe_n, wait_input, bus_request_in, bus_grant_out, processor_clock_output;
    wire [31:0] reg_rdata, resp_rdata, shared_addr_data_lines_in, shared_addr_data_lines_out;
    wire [31:0] shared_addr_data_lines_oe_n;
    wire [3:0] byte_write_strobes_n;
    integer err_total = 0, tests_run = 0, cyc = 0, t_avs = 0, t_wrb = 0, t_rf = 0, rf_gap = 0, avs_low = 0;
    integer rf_mark, span = 0;
    mem_bus_cycles uut (.*);
    mem_far_side far (.*);
    always #4 clk_sys = ~clk_sys;
    // ----
    // Pin timestamps.
    // ----
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        p_avs <= address_valid_strobe_n;
        p_wrb <= &byte_write_strobes_n;
        p_rf <= refresh_cycle_strobe_n;
        if (!address_valid_strobe_n)
            avs_low <= p_avs ? 1 : avs_low + 1;
        if (p_avs && !address_valid_strobe_n) begin
            word <= shared_addr_data_lines_out;
            t_avs <= cyc;
        end
        if (p_avs && !address_valid_strobe_n && !refresh_cycle_strobe_n) begin
            row_prev <= row_cur;
            row_cur <= shared_addr_data_lines_out[11:2];
        end
        if (p_wrb && !(&byte_write_strobes_n))
            t_wrb <= cyc;
        if (p_rf && !refresh_cycle_strobe_n) begin
            rf_gap <= cyc - t_rf;
            t_rf <= cyc;
        end
    end
    task chk(input string name, input [31:0] exp, input [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task reg_wr_t(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task reg_rd_t(input [7:0] a, output [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task cyc_t(input w, input [31:2] a, input [31:0] d, input [3:0] be, output [31:0] q);
        integer n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        req_be <= be;
        n = 0;
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        span = n;
        req_valid <= 1'b0;
        while (resp_valid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        span = n - span;
        q = resp_rdata;
        chk("cycle end", 1, resp_valid);
    endtask
    task wait_rf;
        integer t, n;
        t = t_rf;
        n = 0;
        while (t_rf == t && n < 300) begin
            @(posedge clk_sys);
            n = n + 1;
        end
    endtask
    // ----
    // Scenarios.
    // ----
    task t_regs;
        reg [31:0] v;
        reg_rd_t(`REG_CFG, v);
        chk("cfg reset", `CFG_RESET, v);
        reg_wr_t(`REG_CFG, 32'hffff_0000);
        reg_rd_t(`REG_CFG, v);
        chk("cfg off", 32'h0, v);
        rf_mark = t_rf;
        reg_rd_t(8'h40, v);
        chk("unmapped", 32'h0, v);
        $display("done: registers");
    endtask
    task t_write;
        reg [31:0] v;
        cyc_t(1'b1, 30'h3, 32'h11223344, 4'b0101, v);
        chk("write address", {30'h3, 2'b10}, word);
        chk("early strobe", 1, t_wrb - t_avs);
        reg_wr_t(`REG_CFG, 32'h8);
        cyc_t(1'b1, 30'h5, 32'haabbccdd, 4'hf, v);
        chk("late strobe", 2, t_wrb - t_avs);
        cyc_t(1'b0, 30'h3, 32'h0, 4'h0, v);
        chk("lane merge", 32'h00220044, v);
        chk("read address", {30'h3, 2'b11}, word);
        cyc_t(1'b0, 30'h5, 32'h0, 4'h0, v);
        chk("full word", 32'haabbccdd, v);
        $display("done: writes");
    endtask
    task t_wait;
        reg [31:0] v;
        chk("plain span", 4, avs_low);
        @(posedge clk_sys);
        wait_len <= 8'd10;
        cyc_t(1'b0, 30'h3, 32'h0, 4'h0, v);
        chk("waited data", 32'h00220044, v);
        chk("wait stretch", 1, avs_low > 11 && avs_low < 22);
        chk("wait align", 0, avs_low % 2);
        wait_len <= 8'd0;
        chk("refresh off", rf_mark, t_rf);
        $display("done: waits");
    endtask
    task t_refresh;
        integer s;
        reg [31:0] v;
        for (s = 0; s < 4; s = s + 1) begin
            reg_wr_t(`REG_CFG, s * 2 + 1);
            repeat (3) wait_rf;
            chk("refresh gap", 18 * (s + 1), rf_gap);
            chk("row step", 1, row_step);
        end
        repeat (12) @(posedge clk_sys);
        reg_rd_t(`REG_STATUS, v);
        chk("status row", row_cur + 10'h1, v[9:0]);
        reg_wr_t(`REG_CFG, 32'h1);
        cyc_t(1'b0, 30'h5, 32'h0, 4'h0, v);
        chk("read among refresh", 32'haabbccdd, v);
        $display("done: refresh");
    endtask
    task t_dma;
        integer n;
        reg [31:0] v;
        reg_wr_t(`REG_CFG, 32'h0);
        dma_want <= 1'b1;
        n = 0;
        while (bus_grant_out !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk("grant", 1, bus_grant_out);
        repeat (6) @(posedge clk_sys);
        chk("grant held", 1, bus_grant_out);
        dma_want <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk("grant dropped", 0, bus_grant_out);
        cyc_t(1'b0, 30'h3, 32'h0, 4'h0, v);
        chk("after dma", 32'h00220044, v);
        chk("even span", 6, span);
        reg_wr_t(`REG_CFG, 32'h10);
        cyc_t(1'b0, 30'h5, 32'h0, 4'h0, v);
        chk("odd span", 8, span);
        chk("odd data", 32'haabbccdd, v);
        $display("done: dma");
    endtask
    task complete_run;
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // The scenarios take under a thousand cycles; this allows 50000.
    initial begin
        #400000;
        err_total = err_total + 1;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_regs;
        t_write;
        t_wait;
        t_refresh;
        t_dma;
        complete_run;
    end
endmodule // mem_bus_cycles_test
